// file: srm_pkg.sv
// Constants and types shared by the serial readback and channel select block
package srm_pkg;

  // ----------------------------------------------------------------------
  // Register map and widths
  // ----------------------------------------------------------------------
  localparam int REG_BITS = 8;
  localparam int ADDR_BITS = 5;
  localparam int RESULT_BITS = 14;
  localparam int CHSEL_BITS = 4;
  localparam int LINE_COUNT = 8;
  localparam logic [4:0] ADDR_RESULT_LOW = 5'h00;
  localparam logic [4:0] ADDR_RESULT_HIGH = 5'h01;
  localparam logic [4:0] ADDR_GAIN_MUX = 5'h04;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Instruction byte fields
  // ----------------------------------------------------------------------
  localparam int IB_DIRECT = 7;
  localparam int IB_READ = 6;
  localparam int IB_WIDE = 5;
  localparam int IB_ADDR_LSB = 0;
  localparam logic [4:0] BYTE_EDGES = 5'h08;
  localparam logic [4:0] WORD_EDGES = 5'h10;
  localparam logic [2:0] INSTR_LAST_EDGE = 3'h7;
  localparam logic [4:0] FIRST_BYTE_LAST_EDGE = 5'h07;

  // ----------------------------------------------------------------------
  // Result byte layout
  // ----------------------------------------------------------------------
  localparam int LOW_RES_MSB = 5;
  localparam int LOW_POS_LSB = 2;
  localparam int LOW_ZERO_POS = 1;
  localparam int LOW_OVR_POS = 0;
  localparam int HIGH_RES_LSB = 6;

  // ----------------------------------------------------------------------
  // Channel select field
  // ----------------------------------------------------------------------
  localparam int CS_SINGLE_POS = 3;
  localparam int CS_POLARITY_POS = 2;

  // ----------------------------------------------------------------------
  // Serial engine states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SRM_ST_INSTR = 2'b00,
    SRM_ST_READ = 2'b01,
    SRM_ST_WRITE = 2'b10
  } srm_state_t;

endpackage

// file: srm_result_format.sv
// Packs the conversion result and over-range flag into the two result bytes
`timescale 1ns/1ns
`default_nettype none
module srm_result_format (
  // Converter result
  input wire logic [13:0] conversion_result,
  input wire logic over_range_flag,
  input wire logic binary_format,
  // Packed bytes
  output logic [7:0] low_byte,
  output logic [7:0] high_byte
);

  logic [13:0] coded;

  // Two's complement unless straight binary is asked for
  assign coded = binary_format ?
      {~conversion_result[srm_pkg::RESULT_BITS-1], conversion_result[12:0]} :
      conversion_result;

  assign low_byte = {coded[srm_pkg::LOW_RES_MSB:0], 1'b0, over_range_flag};
  assign high_byte = coded[srm_pkg::RESULT_BITS-1:srm_pkg::HIGH_RES_LSB];

endmodule
`default_nettype wire

// file: srm_mux_decode.sv
// Decodes the channel select field into positive and negative line enables
`timescale 1ns/1ns
`default_nettype none
module srm_mux_decode (
  // Channel select field
  input wire logic [3:0] channel_select_field,
  // Line enables, negative all zero means ground reference
  output logic [7:0] pos_lines,
  output logic [7:0] neg_lines,
  output logic single_ended
);

  logic [2:0] even_line;
  logic [2:0] odd_line;

  assign single_ended = channel_select_field[srm_pkg::CS_SINGLE_POS];
  assign even_line = {channel_select_field[1:0], 1'b0};
  assign odd_line = {channel_select_field[1:0], 1'b1};

  always_comb begin
    pos_lines = 8'h00;
    neg_lines = 8'h00;
    if (single_ended) begin
      pos_lines[channel_select_field[2:0]] = 1'b1;
    end else if (channel_select_field[srm_pkg::CS_POLARITY_POS]) begin
      pos_lines[odd_line] = 1'b1;
      neg_lines[even_line] = 1'b1;
    end else begin
      pos_lines[even_line] = 1'b1;
      neg_lines[odd_line] = 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: srm_serial_readback.sv
// Serial read engine, result registers and input channel selection
//
// Functional notes
// - Drive read data after instruction's eighth edge.
// - Change read data only on non-active edges.
// - Two-wire: release shared line after last bit.
// - Data out line high impedance only while deselected.
// - Behaviour independent of clock idle level.
// - After read, await next instruction byte.
// - Byte reflects state at its first edge.
// - Second byte address: odd minus, even plus.
// - Channel from direct instruction or register four.
// - Top select bit: differential or single-ended.
// - Bit two reverses differential pair polarity.
// - Low two bits pick adjacent input pair.
// - Single-ended: low three bits pick line.
// - Registers eight bits, reset to zero.
// - Result registers at addresses zero, one read-only.
// - Low byte: result five-zero, zero, over-range.
// - High byte holds result thirteen to six.
// - Result coded two's complement by default.
// - Over-range flag marks possibly invalid result.
// - Serial bit order follows bit-order setting.
// - Instruction bit six reads, bit five wide.
// - Chip select high resets serial interface.
`timescale 1ns/1ns
`default_nettype none
module srm_serial_readback (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Serial pins
  input wire logic cs_b,
  input wire logic sclk,
  input wire logic din_in,
  input wire logic sclk_rising_active,
  output logic din_out,
  output logic din_oe,
  output logic dout,
  output logic dout_oe,
  // Serial interface settings
  input wire logic lsb_first,
  input wire logic two_wire_mode,
  // Other registers of the device
  output logic [4:0] read_addr,
  input wire logic [7:0] ext_read_data,
  input wire logic [3:0] gain_mux_channel,
  // Converter side
  input wire logic [13:0] conversion_result,
  input wire logic over_range_flag,
  input wire logic binary_format,
  input wire logic conv_done,
  output logic conv_start,
  output logic [3:0] direct_channel,
  // Multiplexer control
  output logic [7:0] mux_pos_lines,
  output logic [7:0] mux_neg_lines,
  output logic mux_single_ended,
  // Result registers
  output logic [7:0] conversion_result_low,
  output logic [7:0] conversion_result_high
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    // Pin synchronisers
    logic sclk_m;
    logic sclk_s;
    logic sclk_d;
    logic cs_m;
    logic cs_s;
    logic din_m;
    logic din_s;
    logic rise_m;
    logic rise_s;
    // Serial engine
    srm_pkg::srm_state_t state;
    logic [2:0] icount;
    logic [7:0] ishift;
    logic [4:0] dcount;
    logic wide;
    logic [4:0] addr;
    logic [7:0] cap;
    // Pin drivers
    logic dout;
    logic dout_oe;
    logic din_out;
    logic din_oe;
    logic conv_start;
    // Conversion control, channel selection and results
    logic direct_hold;
    logic [3:0] direct_channel;
    logic [3:0] mux_cfg;
    logic [7:0] pos_lines;
    logic [7:0] neg_lines;
    logic single_ended;
    logic [7:0] res_low;
    logic [7:0] res_high;
  } srm_regs_t;

  srm_regs_t s;
  srm_regs_t next_s;

  // Reset image: all zero except the chip select synchroniser, which starts at the
  // deselected level so that no false select drives the data lines after reset
  localparam srm_regs_t RESET_S = '{
    sclk_m: 1'b0,
    sclk_s: 1'b0,
    sclk_d: 1'b0,
    cs_m: 1'b1,
    cs_s: 1'b1,
    din_m: 1'b0,
    din_s: 1'b0,
    rise_m: 1'b0,
    rise_s: 1'b0,
    state: srm_pkg::SRM_ST_INSTR,
    icount: 3'h0,
    ishift: srm_pkg::REG_RESET,
    dcount: 5'h00,
    wide: 1'b0,
    addr: 5'h00,
    cap: srm_pkg::REG_RESET,
    dout: 1'b0,
    dout_oe: 1'b0,
    din_out: 1'b0,
    din_oe: 1'b0,
    conv_start: 1'b0,
    direct_hold: 1'b0,
    direct_channel: 4'h0,
    mux_cfg: 4'h0,
    pos_lines: 8'h00,
    neg_lines: 8'h00,
    single_ended: 1'b0,
    res_low: srm_pkg::REG_RESET,
    res_high: srm_pkg::REG_RESET
  };

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Bit order applies both to the instruction and to the data
  function automatic logic pick_bit(input logic [7:0] data, input logic [2:0] pos,
                                    input logic lsb);
    pick_bit = lsb ? data[pos] : data[3'h7 - pos];
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] data, input logic bit_in,
                                          input logic lsb);
    shift_in = lsb ? {bit_in, data[7:1]} : {data[6:0], bit_in};
  endfunction

  function automatic logic [4:0] partner_addr(input logic [4:0] a);
    partner_addr = a[0] ? a - 5'h01 : a + 5'h01;
  endfunction

  // Result bytes come from here; nothing on the serial side can write them
  function automatic logic [7:0] reg_value(input logic [4:0] a, input logic [7:0] lo,
                                           input logic [7:0] hi, input logic [7:0] ext);
    if (a == srm_pkg::ADDR_RESULT_LOW) begin
      reg_value = lo;
    end else if (a == srm_pkg::ADDR_RESULT_HIGH) begin
      reg_value = hi;
    end else begin
      reg_value = ext;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Edge detection and submodules
  // ----------------------------------------------------------------------
  logic rise_edge;
  logic fall_edge;
  logic act_edge;
  logic nact_edge;
  logic [7:0] instr_byte;
  logic [7:0] live_byte;
  logic [7:0] tx_byte;
  logic [4:0] total_edges;
  logic byte_start;
  logic [7:0] fmt_low;
  logic [7:0] fmt_high;
  logic [7:0] dec_pos;
  logic [7:0] dec_neg;
  logic dec_single;

  // Only edges are used, so the idle level of the clock never matters
  assign rise_edge = s.sclk_s & ~s.sclk_d;
  assign fall_edge = ~s.sclk_s & s.sclk_d;
  assign act_edge = s.rise_s ? rise_edge : fall_edge;
  assign nact_edge = s.rise_s ? fall_edge : rise_edge;
  assign instr_byte = shift_in(s.ishift, s.din_s, lsb_first);
  assign live_byte = reg_value(s.addr, s.res_low, s.res_high, ext_read_data);
  assign byte_start = (s.dcount[2:0] == 3'h0);
  // First bit of a byte goes out before its first active edge, so it is taken live
  assign tx_byte = byte_start ? live_byte : s.cap;
  assign total_edges = s.wide ? srm_pkg::WORD_EDGES : srm_pkg::BYTE_EDGES;

  srm_result_format u_format (
    .conversion_result(conversion_result),
    .over_range_flag(over_range_flag),
    .binary_format(binary_format),
    .low_byte(fmt_low),
    .high_byte(fmt_high)
  );

  srm_mux_decode u_decode (
    .channel_select_field(s.mux_cfg),
    .pos_lines(dec_pos),
    .neg_lines(dec_neg),
    .single_ended(dec_single)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_s = s;
    // Clock, select, data in and active-edge setting pins pass two flip-flops before any logic reads them
    next_s.sclk_m = sclk;
    next_s.sclk_s = s.sclk_m;
    next_s.sclk_d = s.sclk_s;
    next_s.cs_m = cs_b;
    next_s.cs_s = s.cs_m;
    next_s.din_m = din_in;
    next_s.din_s = s.din_m;
    next_s.rise_m = sclk_rising_active;
    next_s.rise_s = s.rise_m;
    next_s.conv_start = 1'b0;

    if (conv_done) begin
      next_s.res_low = fmt_low;
      next_s.res_high = fmt_high;
    end

    // Channel comes from a direct start until register four is written again
    next_s.mux_cfg = s.direct_hold ? s.direct_channel : gain_mux_channel;
    next_s.pos_lines = dec_pos;
    next_s.neg_lines = dec_neg;
    next_s.single_ended = dec_single;

    if (s.cs_s) begin
      // Deselect resets only the serial engine, never the result registers
      next_s.state = srm_pkg::SRM_ST_INSTR;
      next_s.icount = 3'h0;
      next_s.dcount = 5'h00;
      next_s.dout_oe = 1'b0;
      next_s.din_oe = 1'b0;
    end else begin
      next_s.dout_oe = 1'b1;
      case (s.state)
        srm_pkg::SRM_ST_INSTR: begin
          if (act_edge) begin
            next_s.ishift = instr_byte;
            next_s.icount = s.icount + 3'h1;
            if (s.icount == srm_pkg::INSTR_LAST_EDGE) begin
              next_s.dcount = 5'h00;
              next_s.wide = instr_byte[srm_pkg::IB_WIDE];
              next_s.addr = instr_byte[srm_pkg::IB_ADDR_LSB +: srm_pkg::ADDR_BITS];
              if (instr_byte[srm_pkg::IB_DIRECT]) begin
                next_s.conv_start = 1'b1;
                next_s.direct_hold = 1'b1;
                next_s.direct_channel = instr_byte[srm_pkg::CHSEL_BITS-1:0];
              end else if (instr_byte[srm_pkg::IB_READ]) begin
                next_s.state = srm_pkg::SRM_ST_READ;
              end else begin
                next_s.state = srm_pkg::SRM_ST_WRITE;
                // A write to register four hands the channel back to it
                if (instr_byte[srm_pkg::ADDR_BITS-1:0] == srm_pkg::ADDR_GAIN_MUX) begin
                  next_s.direct_hold = 1'b0;
                end
              end
            end
          end
        end
        srm_pkg::SRM_ST_READ: begin
          if (act_edge) begin
            if (byte_start) begin
              next_s.cap = live_byte;
            end
            if (s.wide && s.dcount == srm_pkg::FIRST_BYTE_LAST_EDGE) begin
              next_s.addr = partner_addr(s.addr);
            end
            next_s.dcount = s.dcount + 5'h01;
          end else if (nact_edge) begin
            if (s.dcount == total_edges) begin
              next_s.din_oe = 1'b0;
              next_s.state = srm_pkg::SRM_ST_INSTR;
              next_s.icount = 3'h0;
            end else begin
              next_s.dout = pick_bit(tx_byte, s.dcount[2:0], lsb_first);
              next_s.din_out = pick_bit(tx_byte, s.dcount[2:0], lsb_first);
              next_s.din_oe = two_wire_mode;
            end
          end
        end
        srm_pkg::SRM_ST_WRITE: begin
          // Write data is not stored here; only its length is tracked to stay in step
          if (act_edge) begin
            next_s.dcount = s.dcount + 5'h01;
            if (s.dcount + 5'h01 == total_edges) begin
              next_s.state = srm_pkg::SRM_ST_INSTR;
              next_s.icount = 3'h0;
            end
          end
        end
        default: begin
          next_s.state = srm_pkg::SRM_ST_INSTR;
          next_s.icount = 3'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s <= RESET_S;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign dout = s.dout;
  assign dout_oe = s.dout_oe;
  assign din_out = s.din_out;
  assign din_oe = s.din_oe;
  assign read_addr = s.addr;
  assign conv_start = s.conv_start;
  assign direct_channel = s.direct_channel;
  assign mux_pos_lines = s.pos_lines;
  assign mux_neg_lines = s.neg_lines;
  assign mux_single_ended = s.single_ended;
  assign conversion_result_low = s.res_low;
  assign conversion_result_high = s.res_high;

endmodule
`default_nettype wire

// file: srm_end.sv
// Closing file of the block's sources; it holds no code
`default_nettype none
`default_nettype wire

// file: srm_properties.sv
// Port-level checks on the serial readback and channel select block
`timescale 1ns/1ns
`default_nettype none
module srm_properties (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Serial pins and settings
  input wire logic cs_b,
  input wire logic din_oe,
  input wire logic dout_oe,
  input wire logic two_wire_mode,
  // Converter side
  input wire logic [13:0] conversion_result,
  input wire logic over_range_flag,
  input wire logic binary_format,
  input wire logic conv_done,
  input wire logic conv_start,
  // Multiplexer and result registers
  input wire logic [7:0] mux_pos_lines,
  input wire logic [7:0] mux_neg_lines,
  input wire logic mux_single_ended,
  input wire logic [7:0] conversion_result_low,
  input wire logic [7:0] conversion_result_high
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------------
  // Expected result bytes, latched when a conversion completes
  // ----------------------------------------------------------------------
  logic [7:0] low_exp;
  logic [7:0] high_exp;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      low_exp <= 8'h00;
      high_exp <= 8'h00;
    end else if (conv_done) begin
      low_exp <= {conversion_result[5:0], 1'b0, over_range_flag};
      high_exp <= {conversion_result[13] ^ binary_format, conversion_result[12:6]};
    end
  end
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  chk_oe_deselect: assert property (cs_b [*4] |-> !dout_oe && !din_oe)
    else $error("data line enabled while deselected");
  chk_oe_selected: assert property (!cs_b [*5] |-> dout_oe)
    else $error("data out not driven while selected");
  chk_shared_mode: assert property ($rose(din_oe) |-> two_wire_mode)
    else $error("shared line driven outside two-wire mode");
  chk_low_zero: assert property (conversion_result_low[1] == 1'b0)
    else $error("fixed zero bit of low result set");
  chk_low_load: assert property (conv_done |=> conversion_result_low == low_exp)
    else $error("low result byte wrong after conversion");
  chk_high_load: assert property (conv_done |=> conversion_result_high == high_exp)
    else $error("high result byte wrong after conversion");
  chk_result_hold: assert property (!conv_done |=> $stable(conversion_result_low)
    && $stable(conversion_result_high))
    else $error("result bytes changed without conversion");
  chk_pair_lines: assert property (!mux_single_ended && mux_pos_lines != 8'h00
    |-> $onehot(mux_pos_lines) && (mux_pos_lines | mux_neg_lines) inside
    {8'h03, 8'h0c, 8'h30, 8'hc0})
    else $error("differential lines not an adjacent pair");
  chk_single_line: assert property (mux_single_ended
    |-> $onehot(mux_pos_lines) && mux_neg_lines == 8'h00)
    else $error("single-ended selection not one line to ground");
  chk_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse longer than one cycle");
  cov_conv_done: cover property (conv_done);
  cov_shared_drive: cover property ($rose(din_oe));
  cov_single: cover property (mux_single_ended);
  cov_start: cover property (conv_start);
endmodule
bind srm_serial_readback srm_properties srm_properties_i (
  .mclk(mclk), .rst_b(rst_b), .cs_b(cs_b), .din_oe(din_oe), .dout_oe(dout_oe),
  .two_wire_mode(two_wire_mode), .conversion_result(conversion_result),
  .over_range_flag(over_range_flag), .binary_format(binary_format), .conv_done(conv_done),
  .conv_start(conv_start), .mux_pos_lines(mux_pos_lines), .mux_neg_lines(mux_neg_lines),
  .mux_single_ended(mux_single_ended), .conversion_result_low(conversion_result_low),
  .conversion_result_high(conversion_result_high));
`default_nettype wire

// file: srm_host_model.sv
// Host controller model that runs instruction and read frames on the serial pins
`timescale 1ns/1ns
`default_nettype none
module srm_host_model (
  // Clock
  input wire logic mclk,
  // Serial pins
  output var logic cs_b,
  output var logic sclk,
  output var logic host_din,
  output var logic host_oe,
  input wire logic din_line,
  input wire logic dout_line,
  // Settings
  input wire logic rising_active,
  input wire logic lsb_first,
  input wire logic two_wire_mode,
  // Returned data
  output var logic rd_valid,
  output var logic [15:0] rd_data
);
  initial begin
    cs_b = 1'b1;
    sclk = 1'b0;
    host_din = 1'b0;
    host_oe = 1'b1;
    rd_valid = 1'b0;
    rd_data = 16'h0000;
  end
  // Non-active phase is 5 cycles, active 3: the device answers 3-4 cycles after the
  // non-active edge, so a symmetric clock would sample on the very edge of the change
  task automatic frame(input logic [7:0] instr, input int nbits, input logic last);
    logic [15:0] got;
    int k;
    int j;
    got = 16'h0000;
    @(posedge mclk);
    cs_b <= 1'b0;
    sclk <= ~rising_active;
    repeat (4) @(posedge mclk);
    for (k = 0; k < 8 + nbits; k++) begin
      @(posedge mclk);
      sclk <= ~rising_active;
      host_oe <= (k < 8);
      if (k < 8) host_din <= lsb_first ? instr[k] : instr[7 - k];
      else host_din <= ~host_din;
      repeat (4) @(posedge mclk);
      @(posedge mclk);
      j = k - 8;
      if (k >= 8) got[j / 8 * 8 + (lsb_first ? j % 8 : 7 - j % 8)] = two_wire_mode ?
        din_line : dout_line;
      sclk <= rising_active;
      repeat (2) @(posedge mclk);
    end
    @(posedge mclk);
    sclk <= ~rising_active;
    repeat (6) @(posedge mclk);
    // Take the shared line back only once the device has let go of it
    host_oe <= 1'b1;
    if (last) cs_b <= 1'b1;
    rd_data <= got;
    rd_valid <= (instr[7:6] == 2'b01);
    @(posedge mclk);
    rd_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: srm_tb.sv
// Self-checking testbench for the serial readback and channel select block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  int n_errors = 0;
  int samples_checked = 0;
  int n_starts = 0;
`define CHECK(what, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("unexpected %s: expected %h, seen %h", what, exp, got); \
    end \
  end
  logic mclk, rst_b, sclk_rising_active, lsb_first, two_wire_mode;
  logic over_range_flag, binary_format, conv_done, conv_start;
  logic cs_b, sclk, host_din, host_oe, din_out, din_oe, dout, dout_oe, rd_valid;
  logic [3:0] gain_mux_channel, direct_channel;
  logic [4:0] read_addr;
  logic [13:0] conversion_result;
  logic [7:0] mux_pos_lines, mux_neg_lines, conversion_result_low, conversion_result_high;
  logic mux_single_ended;
  logic [15:0] rd_data, exp_w;
  logic [15:0] exp_q[$];
  wire din_w = din_oe ? din_out : (host_oe ? host_din : ~din_out);
  wire dout_w = dout_oe ? dout : ~dout;
  function automatic logic [7:0] ext_val(input logic [4:0] a);
    return {a, 3'h5} ^ 8'h3c;
  endfunction
  wire [7:0] ext_read_data = ext_val(read_addr);
  function automatic logic [7:0] exp_reg(input logic [4:0] a);
    if (a == 5'h00) return {conversion_result[5:0], 1'b0, over_range_flag};
    if (a == 5'h01) return {conversion_result[13] ^ binary_format, conversion_result[12:6]};
    return ext_val(a);
  endfunction
  srm_serial_readback srm_serial_readback_i (.mclk(mclk), .rst_b(rst_b), .cs_b(cs_b),
    .sclk(sclk), .din_in(din_w), .sclk_rising_active(sclk_rising_active),
    .din_out(din_out), .din_oe(din_oe), .dout(dout), .dout_oe(dout_oe),
    .lsb_first(lsb_first), .two_wire_mode(two_wire_mode), .read_addr(read_addr),
    .ext_read_data(ext_read_data), .gain_mux_channel(gain_mux_channel),
    .conversion_result(conversion_result), .over_range_flag(over_range_flag),
    .binary_format(binary_format), .conv_done(conv_done), .conv_start(conv_start),
    .direct_channel(direct_channel), .mux_pos_lines(mux_pos_lines),
    .mux_neg_lines(mux_neg_lines), .mux_single_ended(mux_single_ended),
    .conversion_result_low(conversion_result_low),
    .conversion_result_high(conversion_result_high));
  srm_host_model srm_host_model_i (.mclk(mclk), .cs_b(cs_b), .sclk(sclk),
    .host_din(host_din), .host_oe(host_oe), .din_line(din_w), .dout_line(dout_w),
    .rising_active(sclk_rising_active), .lsb_first(lsb_first),
    .two_wire_mode(two_wire_mode), .rd_valid(rd_valid), .rd_data(rd_data));
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Queues the expected bytes, then runs the frame; second byte is zero for 8-bit reads
  task automatic rd(input logic [4:0] a, input logic wide, input logic last);
    logic [4:0] b;
    b = a[0] ? a - 5'h01 : a + 5'h01;
    exp_q.push_back({wide ? exp_reg(b) : 8'h00, exp_reg(a)});
    srm_host_model_i.frame({2'b01, wide, a}, wide ? 16 : 8, last);
    `CHECK("shared line release", 1'b0, din_oe)
  endtask
  task automatic chk_mux(input logic [3:0] m);
    logic [7:0] p;
    logic [7:0] n;
    p = m[3] ? 8'h01 << m[2:0] : 8'h01 << {m[1:0], m[2]};
    n = m[3] ? 8'h00 : 8'h01 << {m[1:0], ~m[2]};
    `CHECK("positive lines", p, mux_pos_lines)
    `CHECK("negative lines", n, mux_neg_lines)
    `CHECK("single ended", m[3], mux_single_ended)
  endtask
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // ----------------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------------
  always @(posedge mclk) begin
    if (conv_start === 1'b1) n_starts++;
    if (rd_valid === 1'b1) begin
      exp_w = exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx;
      `CHECK("read data", exp_w, rd_data)
    end
  end
  initial begin
    #3000000;
    n_errors++;
    report_and_stop();
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    int i;
    logic [3:0] m;
    rst_b = 1'b0;
    {sclk_rising_active, lsb_first, two_wire_mode, over_range_flag} = 4'h0;
    {binary_format, conv_done} = 2'b00;
    gain_mux_channel = 4'h0;
    conversion_result = 14'h0000;
    i = $urandom(32'h5398);
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (6) @(posedge mclk);
    `CHECK("result low", 8'h00, conversion_result_low)
    `CHECK("result high", 8'h00, conversion_result_high)
    for (i = 0; i < 8; i++) begin
      @(posedge mclk);
      lsb_first <= i[0];
      two_wire_mode <= i[1];
      sclk_rising_active <= i[2];
      conversion_result <= 14'($urandom);
      over_range_flag <= 1'($urandom);
      binary_format <= 1'($urandom);
      conv_done <= 1'b1;
      @(posedge mclk);
      conv_done <= 1'b0;
      repeat (4) @(posedge mclk);
      rd(5'h00, 1'b0, 1'b1);
      rd(5'h01, 1'b1, 1'b0);
      rd(5'h00, 1'b1, 1'b0);
      rd(5'h01, 1'b0, 1'b0);
      rd(5'($urandom_range(31, 2)), 1'b1, 1'b1);
    end
    for (i = 0; i < 16; i++) begin
      @(posedge mclk);
      gain_mux_channel <= i[3:0];
      repeat (4) @(posedge mclk);
      chk_mux(i[3:0]);
    end
    m = 4'($urandom);
    @(posedge mclk);
    gain_mux_channel <= ~m;
    srm_host_model_i.frame({4'h8, m}, 0, 1'b1);
    repeat (4) @(posedge mclk);
    `CHECK("start pulses", 1, n_starts)
    `CHECK("direct channel", m, direct_channel)
    chk_mux(m);
    srm_host_model_i.frame(8'h04, 8, 1'b1);
    repeat (4) @(posedge mclk);
    chk_mux(~m);
    `CHECK("pending reads", 0, exp_q.size())
    report_and_stop();
  end
endmodule
`default_nettype wire
